/* design/efm_device.sv */
// modulator control: register set, seed reload, resets
`timescale 1ns/1ps
module efm_device
  import efm_pkg::*;
#(
  parameter int POR_CNT = POR_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  efm_if.dev link,
  output logic [23:0] int_div,
  output logic [23:0] frac_word,
  output logic [23:0] mod_cfg,
  output logic [23:0] exact_steps,
  output logic [23:0] phase_accumulator,
  output logic por_done,
  output logic spi_mode
);
  // a zero count would leave the link refused for 2^32 cycles
  if (POR_CNT < 1) begin : g_por_chk
    $error("POR_CNT must be at least 1");
  end
  logic [31:0] por_cnt_ff, nxt_por_cnt;
  logic [23:0] int_ff, nxt_int, frac_ff, nxt_frac, cfg_ff, nxt_cfg, ex_ff, nxt_ex;
  logic [23:0] acc_ff, nxt_acc, rd_ff, nxt_rd;
  logic ack_ff, nxt_ack, mode_ff, nxt_mode, done_ff, nxt_done;
  function automatic logic [23:0] seed_val(input logic [1:0] s);
    case (s)
      2'd0: seed_val = SEED_VAL0;
      2'd1: seed_val = SEED_VAL1;
      2'd2: seed_val = SEED_VAL2;
      default: seed_val = SEED_VAL3;
    endcase
  endfunction
  always_comb begin
    nxt_por_cnt = por_cnt_ff;
    nxt_done = done_ff;
    nxt_int = int_ff;
    nxt_frac = frac_ff;
    nxt_cfg = cfg_ff;
    nxt_ex = ex_ff;
    nxt_mode = mode_ff;
    nxt_ack = 1'b0;
    nxt_rd = rd_ff;
    nxt_acc = 24'(acc_ff + frac_ff); // wraps like the modulus
    if (!done_ff) begin
      // registers held at defaults until the power-on delay has run
      nxt_por_cnt = por_cnt_ff + 32'd1;
      if (por_cnt_ff >= 32'(POR_CNT - 1)) nxt_done = 1'b1;
    end else if (link.req && !ack_ff) begin
      nxt_ack = 1'b1;
      if (link.we) begin
        case (link.addr)
          REG_CHIP_INFO: begin
            // soft reset; mode bit kept, oscillator-side state lives elsewhere
            nxt_int = INT_DIV_RST;
            nxt_frac = FRAC_RST;
            nxt_cfg = MOD_CFG_RST;
            nxt_ex = EXACT_RST;
            nxt_acc = seed_val(MOD_CFG_RST[SEED_LSB +: SEED_W]);
          end
          REG_INT_DIV: nxt_int = link.wdata;
          REG_FRAC: begin
            nxt_frac = link.wdata;
            nxt_acc = seed_val(cfg_ff[SEED_LSB +: SEED_W]);
          end
          REG_MOD_CFG: nxt_cfg = link.wdata;
          REG_EXACT_STEPS: nxt_ex = link.wdata;
          default: nxt_mode = link.wdata[SPI_MODE_POS] ? 1'b1 : mode_ff;
        endcase
      end else begin
        case (link.addr)
          REG_CHIP_INFO: nxt_rd = CHIP_VERSION;
          REG_INT_DIV: nxt_rd = int_ff;
          REG_FRAC: nxt_rd = frac_ff;
          REG_MOD_CFG: nxt_rd = cfg_ff;
          REG_EXACT_STEPS: nxt_rd = ex_ff;
          default: nxt_rd = 24'h00_0000;
        endcase
      end
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      por_cnt_ff <= 32'h0000_0000;
      done_ff <= 1'b0;
      int_ff <= INT_DIV_RST;
      frac_ff <= FRAC_RST;
      cfg_ff <= MOD_CFG_RST;
      ex_ff <= EXACT_RST;
      acc_ff <= SEED_VAL0;
      mode_ff <= 1'b0;
      ack_ff <= 1'b0;
      rd_ff <= 24'h00_0000;
    end else begin
      por_cnt_ff <= nxt_por_cnt;
      done_ff <= nxt_done;
      int_ff <= nxt_int;
      frac_ff <= nxt_frac;
      cfg_ff <= nxt_cfg;
      ex_ff <= nxt_ex;
      acc_ff <= nxt_acc;
      mode_ff <= nxt_mode;
      ack_ff <= nxt_ack;
      rd_ff <= nxt_rd;
    end
  end
  assign link.ack = ack_ff;
  assign link.rdata = rd_ff;
  assign int_div = int_ff;
  assign frac_word = frac_ff;
  assign mod_cfg = cfg_ff;
  assign exact_steps = ex_ff;
  assign phase_accumulator = acc_ff;
  assign por_done = done_ff;
  assign spi_mode = mode_ff;
endmodule

/* design/efm_host.sv */
// axi4-lite host controller that drives the modulator control link

`timescale 1ns/1ps
module efm_host
  import efm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  efm_if.host link,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // the link slices below are fixed at five address and 24 data bits
  if (ADDR_W != 5 || DATA_W != 24) begin : g_width_chk
    $error("link widths do not match the host register slices");
  end

  typedef enum logic [1:0] {IDLE, FIRST, XFER} st_t;
  st_t st_ff, nxt_st;
  logic [4:0] addr_ff, nxt_addr;
  logic [23:0] wd_ff, nxt_wd, rd_ff, nxt_rd;
  logic rdop_ff, nxt_rdop, bad_ff, nxt_bad, req_ff, nxt_req, we_ff, nxt_we;
  logic aw_ff, nxt_aw, w_ff, nxt_w, bv_ff, nxt_bv, rv_ff, nxt_rv;
  logic [7:0] awa_ff, nxt_awa;
  logic [31:0] wdat_ff, nxt_wdat, rdat_ff, nxt_rdat;
  logic [3:0] wstb_ff, nxt_wstb;
  logic busy;

  assign busy = (st_ff != IDLE);

  // byte lanes without a strobe keep their old contents
  function automatic logic [31:0] byte_merge(input logic [31:0] cur, input logic [31:0] upd,
      input logic [3:0] strb);
    logic [31:0] res;
    res = cur;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) res[8*i +: 8] = upd[8*i +: 8];
    end
    return res;
  endfunction

  always_comb begin
    nxt_aw = aw_ff;
    nxt_wstb = wstb_ff;
    nxt_w = w_ff;
    nxt_awa = awa_ff;
    nxt_wdat = wdat_ff;
    nxt_bv = bv_ff;
    nxt_rv = rv_ff;
    nxt_rdat = rdat_ff;
    nxt_st = st_ff;
    nxt_addr = addr_ff;
    nxt_wd = wd_ff;
    nxt_rd = rd_ff;
    nxt_rdop = rdop_ff;
    nxt_bad = bad_ff;
    nxt_req = req_ff;
    nxt_we = we_ff;

    // address and data may come in either order; each waits for the other
    if (s_axi_awvalid && !aw_ff && !bv_ff) begin
      nxt_aw = 1'b1;
      nxt_awa = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && !w_ff && !bv_ff) begin
      nxt_w = 1'b1;
      nxt_wdat = s_axi_wdata;
      nxt_wstb = s_axi_wstrb;
    end
    // ready stays low until the response is taken: one write at a time
    if (aw_ff && w_ff && !bv_ff) begin
      nxt_aw = 1'b0;
      nxt_w = 1'b0;
      nxt_bv = 1'b1;
      case (awa_ff)
        H_CTRL: if (wstb_ff[0] && wdat_ff[CTRL_GO] && !busy) begin
          nxt_rdop = wdat_ff[CTRL_READ];
          // a go while a transfer is running is dropped, not queued
          nxt_st = FIRST;
        end
        H_ADDR: nxt_addr = 5'(byte_merge({27'h000_0000, addr_ff}, wdat_ff, wstb_ff));
        H_WDATA: nxt_wd = 24'(byte_merge({8'h00, wd_ff}, wdat_ff, wstb_ff));
        default: ;
      endcase
    end
    if (bv_ff && s_axi_bready) nxt_bv = 1'b0;

    // read data is captured once and stands until rready
    if (s_axi_arvalid && !rv_ff) begin
      nxt_rv = 1'b1;
      case (s_axi_araddr[7:0])
        H_ADDR: nxt_rdat = {27'h000_0000, addr_ff};
        H_WDATA: nxt_rdat = {8'h00, wd_ff};
        H_RDATA: nxt_rdat = {8'h00, rd_ff};
        H_STATUS: nxt_rdat = {30'h0000_0000, bad_ff, busy};
        default: nxt_rdat = 32'h0000_0000;
      endcase
    end
    if (rv_ff && s_axi_rready) nxt_rv = 1'b0;

    // one link transfer per go; request held until the acknowledge
    case (st_ff)
      IDLE: ;
      FIRST: begin
        // range check flags divide values the device cannot use
        nxt_bad = !rdop_ff && addr_ff == REG_INT_DIV &&
                  (wd_ff < INT_DIV_MIN || wd_ff > INT_DIV_MAX);
        nxt_req = 1'b1;
        nxt_we = !rdop_ff;
        nxt_st = XFER;
      end
      XFER: if (link.ack) begin
        nxt_req = 1'b0;
        // rdata is sampled in the acknowledge cycle; the device holds it until its next read
        if (rdop_ff) nxt_rd = link.rdata;
        nxt_st = IDLE;
      end
      default: nxt_st = IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= IDLE;
      addr_ff <= 5'h00;
      wd_ff <= 24'h00_0000;
      rd_ff <= 24'h00_0000;
      rdop_ff <= 1'b0;
      bad_ff <= 1'b0;
      req_ff <= 1'b0;
      we_ff <= 1'b0;
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      awa_ff <= 8'h00;
      wdat_ff <= 32'h0000_0000;
      wstb_ff <= 4'h0;
      bv_ff <= 1'b0;
      rv_ff <= 1'b0;
      rdat_ff <= 32'h0000_0000;
    end else begin
      st_ff <= nxt_st;
      addr_ff <= nxt_addr;
      wd_ff <= nxt_wd;
      rd_ff <= nxt_rd;
      rdop_ff <= nxt_rdop;
      bad_ff <= nxt_bad;
      req_ff <= nxt_req;
      we_ff <= nxt_we;
      aw_ff <= nxt_aw;
      w_ff <= nxt_w;
      awa_ff <= nxt_awa;
      wdat_ff <= nxt_wdat;
      wstb_ff <= nxt_wstb;
      bv_ff <= nxt_bv;
      rv_ff <= nxt_rv;
      rdat_ff <= nxt_rdat;
    end
  end

  // software computes the values; only the fraction is rewritten per channel
  assign link.req = req_ff;
  assign link.we = we_ff;
  assign link.addr = addr_ff;
  assign link.wdata = wd_ff;

  // responses are always okay; unmapped offsets read as zero
  assign s_axi_awready = !aw_ff && !bv_ff;
  assign s_axi_wready = !w_ff && !bv_ff;
  assign s_axi_bvalid = bv_ff;
  assign s_axi_bresp = 2'b00;
  assign s_axi_arready = !rv_ff;
  assign s_axi_rvalid = rv_ff;
  assign s_axi_rdata = rdat_ff;
  assign s_axi_rresp = 2'b00;
endmodule

/* shared/efm_if.sv */
// register link between the host controller and the modulator control
`timescale 1ns/1ps
interface efm_if;
  import efm_pkg::*;
  logic req;
  logic we;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic ack;
  logic [DATA_W-1:0] rdata;
  modport dev (input req, we, addr, wdata, output ack, rdata);
  modport host (output req, we, addr, wdata, input ack, rdata);
endinterface

/* shared/efm_pkg.sv */
// shared constants for the exact-frequency modulator control link
package efm_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 24;
  localparam logic [4:0] REG_CHIP_INFO = 5'h00;
  localparam logic [4:0] REG_INT_DIV = 5'h03;
  localparam logic [4:0] REG_FRAC = 5'h04;
  localparam logic [4:0] REG_MOD_CFG = 5'h06;
  localparam logic [4:0] REG_EXACT_STEPS = 5'h0c;
  localparam int SOFT_RESET_BIT_POS = 5;
  localparam int SEED_LSB = 0;
  localparam int SEED_W = 2;
  localparam int SPI_MODE_POS = 6;
  localparam logic [1:0] SEED_RANDOM = 2'h2;
  localparam logic [23:0] INT_DIV_RST = 24'h00_0014;
  localparam logic [23:0] FRAC_RST = 24'h00_0000;
  localparam logic [23:0] MOD_CFG_RST = 24'h00_0000;
  localparam logic [23:0] EXACT_RST = 24'h00_0000;
  // chip version code: arbitrary value
  localparam logic [23:0] CHIP_VERSION = 24'h00_a5c3;
  localparam logic [23:0] INT_DIV_MIN = 24'h00_0014;
  localparam logic [23:0] INT_DIV_MAX = 24'h07_fffc;
  localparam logic [23:0] SEED_VAL0 = 24'h00_0000;
  localparam logic [23:0] SEED_VAL1 = 24'h80_0000;
  localparam logic [23:0] SEED_VAL2 = 24'h5a_3c96;
  localparam logic [23:0] SEED_VAL3 = 24'hff_ffff;
  localparam int POR_TIME_US = 250;
  localparam int CLK_MHZ = 200;
  localparam int POR_CYCLES = POR_TIME_US * CLK_MHZ;
  // host register file offsets (axi byte addresses)
  localparam logic [7:0] H_CTRL = 8'h00;
  localparam logic [7:0] H_ADDR = 8'h04;
  localparam logic [7:0] H_WDATA = 8'h08;
  localparam logic [7:0] H_RDATA = 8'h0c;
  localparam logic [7:0] H_STATUS = 8'h10;
  localparam int CTRL_GO = 0;
  localparam int CTRL_READ = 1;
  localparam int ST_BUSY = 0;
  localparam int ST_BAD = 1;
endpackage

/* sim/efm_checker.sv */
// assertions on the link and the modulator control outputs
`timescale 1ns/1ps
module efm_checker
  import efm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req,
  input wire logic we,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic ack,
  input wire logic [23:0] int_div,
  input wire logic [23:0] frac_word,
  input wire logic [23:0] mod_cfg,
  input wire logic [23:0] phase_accumulator,
  input wire logic por_done,
  input wire logic spi_mode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  function automatic logic [23:0] seed(input logic [1:0] s);
    return s == 2'h0 ? SEED_VAL0 : s == 2'h1 ? SEED_VAL1 : s == 2'h2 ? SEED_VAL2 : SEED_VAL3;
  endfunction
  // a write request followed by its acknowledge
  sequence wr_done(logic [4:0] a);
    req && we && addr == a ##1 ack;
  endsequence
  ack_pulse_a: assert property (ack |=> !ack) else $error("ack longer than one cycle");
  ack_cause_a: assert property ($rose(ack) |-> $past(req)) else $error("ack without request");
  por_block_a: assert property (!por_done |-> !ack) else $error("ack before power-on done");
  frac_load_a: assert property (wr_done(REG_FRAC) |-> frac_word == wdata)
    else $error("fraction not loaded");
  mod_load_a: assert property (wr_done(REG_MOD_CFG) |-> mod_cfg == wdata)
    else $error("config not loaded");
  seed_load_a: assert property (wr_done(REG_FRAC) |->
    phase_accumulator == seed(mod_cfg[1:0])) else $error("start phase not reloaded");
  // no reload at this edge: the accumulator must keep stepping by the fraction
  acc_step_a: assert property (!ack ##1 !ack |->
    phase_accumulator == $past(phase_accumulator) + $past(frac_word))
    else $error("accumulator step wrong");
  soft_rst_a: assert property (wr_done(REG_CHIP_INFO) |-> int_div == INT_DIV_RST
    && frac_word == FRAC_RST && mod_cfg == MOD_CFG_RST) else $error("soft reset missed");
  mode_keep_a: assert property (wr_done(REG_CHIP_INFO) |-> spi_mode == $past(spi_mode))
    else $error("serial mode lost");
endmodule

/* sim/tb_exact_freq_modulator_ctrl.sv */
// axi host drives the link into the modulator control, read results checked from a queue
`timescale 1ns/1ps
module tb_exact_freq_modulator_ctrl;
  import efm_pkg::*;
  logic clk = 0;
  logic rst_n = 0;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [23:0] int_div, frac_word, mod_cfg, exact_steps, phase_accumulator, rnd;
  logic por_done, spi_mode;
  logic [31:0] exp_q[$];
  int acks = 0;
  int num_errors = 0;
  int total_checks = 0;
  efm_if lnk();
  always #2.5 clk = ~clk;
  efm_device #(.POR_CNT(8)) i_efm_device (.clk(clk), .rst_n(rst_n), .link(lnk),
    .int_div(int_div), .frac_word(frac_word), .mod_cfg(mod_cfg), .exact_steps(exact_steps),
    .phase_accumulator(phase_accumulator), .por_done(por_done), .spi_mode(spi_mode));
  efm_host i_efm_host (.clk(clk), .rst_n(rst_n), .link(lnk), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  efm_checker i_efm_checker (.clk(clk), .rst_n(rst_n), .req(lnk.req), .we(lnk.we),
    .addr(lnk.addr), .wdata(lnk.wdata), .ack(lnk.ack), .int_div(int_div),
    .frac_word(frac_word), .mod_cfg(mod_cfg), .phase_accumulator(phase_accumulator),
    .por_done(por_done), .spi_mode(spi_mode));
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 200) begin
      num_errors++;
      $display("[ERR] %0t wait timed out", $time);
      final_report();
    end
  endtask
  // results are compared in arrival order against the driver's notes
  always @(posedge clk) begin
    if (rvalid && rready) begin
      chk({30'h0, rresp}, 32'h0000_0000);
      if (exp_q.size() > 0) chk(rdata, exp_q.pop_front());
      else chk(32'h0000_0000, 32'h0000_0001);
    end
    if (bvalid && bready) chk({30'h0, bresp}, 32'h0000_0000);
    if (lnk.ack) acks++;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    awaddr <= {24'h00_0000, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (!bvalid && n < 200);
    bready <= 1'b0;
    tmo(n);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    int n;
    exp_q.push_back(e);
    @(posedge clk);
    araddr <= {24'h00_0000, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (!rvalid && n < 200);
    rready <= 1'b0;
    tmo(n);
  endtask
  // the acknowledge may land while the control write is still finishing, so count it
  task automatic link(input logic w, input logic [4:0] a, input logic [23:0] d);
    int n;
    int seen;
    wr(H_ADDR, {27'h0, a});
    wr(H_WDATA, {8'h00, d});
    seen = acks;
    wr(H_CTRL, {30'h0, !w, 1'b1});
    n = 0;
    while (acks == seen && n < 200) begin
      @(posedge clk);
      n++;
    end
    tmo(n);
    repeat (2) @(posedge clk);
  endtask
  task automatic dev_rd(input logic [4:0] a, input logic [23:0] e);
    link(1'b0, a, 24'h00_0000);
    rd(H_RDATA, {8'h00, e});
  endtask
  initial begin
    void'($urandom(32'h4a8f_cace));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (12) @(posedge clk);
    chk({31'h0, por_done}, 32'h0000_0001);
    chk({8'h00, int_div}, {8'h00, INT_DIV_RST});
    chk({8'h00, mod_cfg}, {8'h00, MOD_CFG_RST});
    link(1'b1, REG_CHIP_INFO, 24'h00_0020);
    link(1'b1, REG_INT_DIV, 24'h00_002d);
    link(1'b1, REG_EXACT_STEPS, 24'h00_0c00);
    link(1'b1, REG_FRAC, 24'h93_8000);
    dev_rd(REG_INT_DIV, 24'h00_002d);
    dev_rd(REG_EXACT_STEPS, 24'h00_0c00);
    for (int s = 0; s < 4; s++) begin
      rnd = 24'($urandom);
      link(1'b1, REG_MOD_CFG, {22'h0, s[1:0]});
      link(1'b1, REG_FRAC, rnd);
      dev_rd(REG_FRAC, rnd);
      dev_rd(REG_MOD_CFG, {22'h0, s[1:0]});
    end
    link(1'b1, REG_MOD_CFG, {22'h0, SEED_RANDOM});
    link(1'b1, REG_FRAC, 24'h93_faab);
    chk({8'h00, int_div}, 32'h0000_002d);
    chk({8'h00, exact_steps}, 32'h0000_0c00);
    link(1'b1, REG_INT_DIV, 24'h00_0013);
    rd(H_STATUS, 32'h0000_0002);
    link(1'b1, 5'h1f, 24'h00_0040);
    chk({31'h0, spi_mode}, 32'h0000_0001);
    rd(H_STATUS, 32'h0000_0000);
    rd(H_ADDR, 32'h0000_001f);
    rd(H_WDATA, 32'h0000_0040);
    // only byte lane one is strobed, the other lanes must keep their contents
    wstrb <= 4'h2;
    wr(H_WDATA, 32'hffff_ab00);
    wstrb <= 4'hf;
    rd(H_WDATA, 32'h0000_ab40);
    dev_rd(REG_CHIP_INFO, CHIP_VERSION);
    dev_rd(5'h1f, 24'h00_0000);
    link(1'b1, REG_CHIP_INFO, 24'h00_0020);
    chk({8'h00, int_div}, {8'h00, INT_DIV_RST});
    chk({8'h00, frac_word}, {8'h00, FRAC_RST});
    chk({8'h00, mod_cfg}, {8'h00, MOD_CFG_RST});
    chk({8'h00, exact_steps}, {8'h00, EXACT_RST});
    chk({31'h0, spi_mode}, 32'h0000_0001);
    // second reset in mid-run: the link must wait out the power-on delay again
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk({31'h0, por_done}, 32'h0000_0000);
    chk({31'h0, spi_mode}, 32'h0000_0000);
    rst_n <= 1'b1;
    link(1'b1, REG_FRAC, 24'h00_1234);
    chk({8'h00, int_div}, {8'h00, INT_DIV_RST});
    dev_rd(REG_FRAC, 24'h00_1234);
    rd(8'h40, 32'h0000_0000);
    final_report();
  end
endmodule
